// >>> inc/pfl_pkg.sv
// Package: register map, entry field layout and timing constants
package pfl_pkg;
  // ****************************************************
  // Register word indices (word index = printed offset)
  // ****************************************************
  localparam logic [19:0] PORT_A_LOW_IDX  = 20'h78c00;
  localparam logic [19:0] PORT_A_MID_IDX  = 20'h78c01;
  localparam logic [19:0] PORT_A_HIGH_IDX = 20'h78c02;
  localparam logic [19:0] PORT_B_LOW_IDX  = 20'h78c03;
  localparam logic [19:0] PORT_B_MID_IDX  = 20'h78c04;
  localparam logic [19:0] PORT_B_HIGH_IDX = 20'h78c05;
  localparam logic [19:0] CONTROL_IDX     = 20'h78c07;
  // Own registers for the conversion entry and results
  localparam logic [19:0] ENTRY_ADDR_IDX  = 20'h78c10;
  localparam logic [19:0] ENTRY_WIDTH_IDX = 20'h78c11;
  localparam logic [19:0] ENTRY_LIMIT_IDX = 20'h78c12;
  localparam logic [19:0] ABS_SRC_IDX     = 20'h78c13;
  localparam logic [19:0] ABS_FMT_IDX     = 20'h78c14;
  localparam logic [19:0] ABS_CMD_IDX     = 20'h78c15;
  localparam logic [19:0] POSITION_IDX    = 20'h78c16;
  localparam logic [19:0] ABS_POS_IDX     = 20'h78c17;
  localparam logic [19:0] STATION_ONE_IDX = 20'h78c18;
  localparam logic [19:0] STATION_TWO_IDX = 20'h78c19;
  localparam logic [19:0] STATUS_IDX      = 20'h78c1a;
  // ****************************************************
  // Control word bank selection
  // ****************************************************
  localparam logic [1:0] BANK_GRAY  = 2'h2;
  localparam logic [1:0] BANK_LATCH = 2'h3;
  localparam logic [7:0] CONTROL_RESET = 8'h3f;
  localparam logic [7:0] STATION_LATCHED = 8'hc0;
  // ****************************************************
  // Entry field layout
  // ****************************************************
  localparam int MODE_BIT     = 19;
  localparam int METHOD_LSB   = 20;
  localparam int WIDTH_LSB    = 12;
  localparam int LANE_LSB     = 8;
  localparam int FRACTION_BITS = 5;
  localparam logic [3:0] METHOD_PLAIN    = 4'h2;
  localparam logic [3:0] METHOD_FILTER   = 4'h3;
  localparam logic [3:0] METHOD_FILTER_X = 4'h7;
  localparam logic [7:0] WIDTH_ONE_BYTE  = 8'h08;
  localparam logic [7:0] WIDTH_TWO_BYTE  = 8'h10;
  localparam logic [7:0] WIDTH_MAX       = 8'h18;
  localparam logic [3:0] ABS_FMT_DIGIT   = 4'h4;
  localparam int ABS_FMT_ZERO_BIT = 22;
  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_MHZ      = 100;
  localparam int READ_DELAY_US = 2;
  localparam int READ_DELAY_CYC = READ_DELAY_US * CLK_MHZ;
endpackage

// >>> rtl/pfl_input_byte.sv
// One input byte with Gray decode and strobe latch
`timescale 1ns/10ps
module pfl_input_byte (
  input  wire logic       CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic [7:0] PIN_I,
  input  wire logic [7:0] GRAY_MASK_I,
  input  wire logic [7:0] LATCH_MASK_I,
  input  wire logic       STROBE_I,
  output logic      [7:0] DATA_O
);
  logic [7:0] held;
  logic [7:0] gray_bin;

  // Gray to binary across all eight bits, mask applied below
  always_comb begin
    gray_bin[7] = PIN_I[7];
    for (int i = 6; i >= 0; i--) begin
      gray_bin[i] = gray_bin[i+1] ^ PIN_I[i];
    end
  end

  // Held value changes only on strobe
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      held <= 8'h00;
    end else if (STROBE_I) begin
      held <= (gray_bin & GRAY_MASK_I) | (PIN_I & ~GRAY_MASK_I); // see RL20
    end
  end

  // Latched bits show held, others live
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      DATA_O <= 8'h00;
    end else begin
      DATA_O <= (held & LATCH_MASK_I) |
                (((gray_bin & GRAY_MASK_I) | (PIN_I & ~GRAY_MASK_I)) & ~LATCH_MASK_I); // see RL13
    end
  end
endmodule

// >>> rtl/parallel_feedback_latch_reader.sv
// Parallel feedback reader: input board, conversion entry, absolute read
// What this block does
// RL1: method 2 unfiltered, 3 filtered
// RL2: width digits 01 to 18 hex
// RL3: one, two or three bytes by width
// RL4: lane digit picks source byte lane
// RL5: LSB position 0 to 7 in base
// RL6: method 3 or 7 limits change
// RL7: absolute read at reset and request
// RL8: absolute format low byte, bit22 zero
// RL9: sample 2 us after servo fall
// RL10: fault inputs abort latch, polarity selectable
// RL11: control bits 7:6 select setup banks
// RL12: bank 2 bits choose Gray decoding
// RL13: bank 3 bits choose latching
// RL14: controller restores control word 3F
// RL15: station latches inputs on phase clock
// RL16: station words: C0 latched per ASIC
// RL17: bit 19 selects five fraction bits
// RL18: bits 0-18 give base address
// RL19: assemble bytes low first, then trim
// RL20: latched byte changes only on strobe
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module parallel_feedback_latch_reader (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic [47:0] FEEDBACK_PINS_I,
  input  wire logic        SERVO_CLK_I,
  input  wire logic        PHASE_CLK_I,
  input  wire logic        STATION_MODE_I,
  input  wire logic        FEEDBACK_FAULT_IN_FIRST_N_I,
  input  wire logic        FEEDBACK_FAULT_IN_SECOND_N_I,
  input  wire logic        FAULT_POLARITY_JUMPER_FIRST_I,
  input  wire logic        FAULT_POLARITY_JUMPER_SECOND_I,
  output logic      [23:0] MOTOR_POSITION_O,
  output logic             POSITION_VALID_O
);
  import pfl_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_DONE  = 4'b1000
  } conv_state_t;

  conv_state_t state;
  logic [7:0]  control;
  logic [47:0] gray_mask;
  logic [47:0] latch_mask;
  logic [47:0] station_one;
  logic [47:0] station_two;
  logic [23:0] entry_addr;
  logic [23:0] entry_width;
  logic [23:0] entry_limit;
  logic [23:0] abs_src;
  logic [23:0] abs_fmt;
  logic [23:0] abs_pos;
  logic        abs_pending;
  logic        abs_cycle;
  logic [47:0] in_bytes;
  logic        servo_d;
  logic        phase_d;
  logic        strobe;
  logic [15:0] delay_cnt;
  logic [1:0]  fetch_idx;
  logic [23:0] gathered;
  logic [23:0] last_pos;
  logic        first_done;
  logic        addr_ph;
  logic        wr_ph;
  logic [19:0] idx_ph;
  logic [23:0] next_raw;
  logic [23:0] next_pos;

  // ****************************************************
  // Helpers
  // ****************************************************
  // Byte at a board index, zero past the sixth byte
  function automatic logic [7:0] board_byte(input logic [47:0] src, input logic [19:0] idx);
    logic [2:0] k;
    k = idx[2:0];
    board_byte = (k < 3'd6) ? src[k*8 +: 8] : 8'h00;
  endfunction

  // Bytes needed for a width
  function automatic logic [1:0] byte_count(input logic [7:0] w);
    if (w <= WIDTH_ONE_BYTE) byte_count = 2'd1;        // see RL3
    else if (w <= WIDTH_TWO_BYTE) byte_count = 2'd2;
    else byte_count = 2'd3;
  endfunction

  // ****************************************************
  // Input bytes
  // ****************************************************
  // Fault asserted per polarity jumper aborts strobe
  logic fault_first;
  logic fault_second;
  assign fault_first  = FEEDBACK_FAULT_IN_FIRST_N_I ^ FAULT_POLARITY_JUMPER_FIRST_I; // see RL10
  assign fault_second = FEEDBACK_FAULT_IN_SECOND_N_I ^ FAULT_POLARITY_JUMPER_SECOND_I;

  // Latch strobe: servo falling edge, or phase clock rising on station
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      servo_d <= 1'b0;
      phase_d <= 1'b0;
    end else begin
      servo_d <= SERVO_CLK_I;
      phase_d <= PHASE_CLK_I;
    end
  end
  assign strobe = STATION_MODE_I ? (PHASE_CLK_I & ~phase_d) // see RL15
                                 : (servo_d & ~SERVO_CLK_I);

  // Effective latch mask: station words or bank 3
  logic [47:0] eff_latch;
  always_comb begin
    eff_latch = latch_mask;
    if (STATION_MODE_I) begin
      // First ASIC digit pair (bits 31:24) of each station word, C0 latches all
      eff_latch[23:0]  = (station_one[31:24] == STATION_LATCHED) ? 24'hffffff : 24'h000000; // see RL16
      eff_latch[47:24] = (station_two[31:24] == STATION_LATCHED) ? 24'hffffff : 24'h000000;
    end
  end

  for (genvar b = 0; b < 6; b++) begin : g_byte
    pfl_input_byte u_byte (
      .CLK_I        (CLK_I),
      .SYS_RST_I    (SYS_RST_I),
      .PIN_I        (FEEDBACK_PINS_I[b*8 +: 8]),
      .GRAY_MASK_I  (gray_mask[b*8 +: 8]),
      .LATCH_MASK_I (eff_latch[b*8 +: 8]),
      .STROBE_I     (strobe & ~((b < 3) ? fault_first : fault_second)), // see RL10
      .DATA_O       (in_bytes[b*8 +: 8])
    );
  end

  // ****************************************************
  // AHB-Lite slave
  // ****************************************************
  // Address phase capture
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      addr_ph <= 1'b0;
      wr_ph   <= 1'b0;
      idx_ph  <= 20'h00000;
    end else if (HREADY_I) begin
      addr_ph <= HSEL_I & HTRANS_I[1];
      wr_ph   <= HWRITE_I;
      idx_ph  <= HADDR_I[21:2];
    end
  end

  // Register writes in the data phase
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      control     <= CONTROL_RESET;
      gray_mask   <= 48'h0;
      latch_mask  <= 48'h0;
      entry_addr  <= 24'hf78c00;
      entry_width <= 24'h218000;
      entry_limit <= 24'h000000;
      abs_src     <= 24'h078c00;
      abs_fmt     <= 24'h018004;
      station_one <= 48'h0;
      station_two <= 48'h0;
    end else if (addr_ph && wr_ph) begin
      if (idx_ph >= PORT_A_LOW_IDX && idx_ph <= PORT_B_HIGH_IDX) begin
        // Byte lane writes land in the selected bank
        if (control[7:6] == BANK_GRAY) begin
          gray_mask[idx_ph[2:0]*8 +: 8] <= HWDATA_I[7:0]; // see RL11, RL12
        end else if (control[7:6] == BANK_LATCH) begin
          latch_mask[idx_ph[2:0]*8 +: 8] <= HWDATA_I[7:0]; // see RL11, RL13
        end
      end else if (idx_ph == CONTROL_IDX) begin
        control <= HWDATA_I[7:0]; // see RL14
      end else if (idx_ph == ENTRY_ADDR_IDX) begin
        entry_addr <= HWDATA_I[23:0];
      end else if (idx_ph == ENTRY_WIDTH_IDX) begin
        entry_width <= HWDATA_I[23:0];
      end else if (idx_ph == ENTRY_LIMIT_IDX) begin
        entry_limit <= HWDATA_I[23:0];
      end else if (idx_ph == ABS_SRC_IDX) begin
        abs_src <= HWDATA_I[23:0];
      end else if (idx_ph == ABS_FMT_IDX) begin
        abs_fmt <= HWDATA_I[23:0];
      end else if (idx_ph == STATION_ONE_IDX) begin
        station_one[31:0] <= HWDATA_I;
      end else if (idx_ph == STATION_TWO_IDX) begin
        station_two[31:0] <= HWDATA_I;
      end
    end
  end

  // Read data registered in address phase
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      HRDATA_O <= 32'h0;
    end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
      if (HADDR_I[21:2] >= PORT_A_LOW_IDX && HADDR_I[21:2] <= PORT_B_HIGH_IDX) begin
        HRDATA_O <= {24'h0, board_byte(in_bytes, HADDR_I[21:2])};
      end else if (HADDR_I[21:2] == CONTROL_IDX) begin
        HRDATA_O <= {24'h0, control};
      end else if (HADDR_I[21:2] == ENTRY_ADDR_IDX) begin
        HRDATA_O <= {8'h0, entry_addr};
      end else if (HADDR_I[21:2] == ENTRY_WIDTH_IDX) begin
        HRDATA_O <= {8'h0, entry_width};
      end else if (HADDR_I[21:2] == ENTRY_LIMIT_IDX) begin
        HRDATA_O <= {8'h0, entry_limit};
      end else if (HADDR_I[21:2] == ABS_SRC_IDX) begin
        HRDATA_O <= {8'h0, abs_src};
      end else if (HADDR_I[21:2] == ABS_FMT_IDX) begin
        HRDATA_O <= {8'h0, abs_fmt};
      end else if (HADDR_I[21:2] == POSITION_IDX) begin
        HRDATA_O <= {8'h0, MOTOR_POSITION_O};
      end else if (HADDR_I[21:2] == ABS_POS_IDX) begin
        HRDATA_O <= {8'h0, abs_pos};
      end else if (HADDR_I[21:2] == STATION_ONE_IDX) begin
        HRDATA_O <= station_one[31:0];
      end else if (HADDR_I[21:2] == STATION_TWO_IDX) begin
        HRDATA_O <= station_two[31:0];
      end else if (HADDR_I[21:2] == STATUS_IDX) begin
        HRDATA_O <= {26'h0, state, abs_pending, POSITION_VALID_O};
      end else begin
        HRDATA_O <= 32'h0;
      end
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // ****************************************************
  // Conversion sequence
  // ****************************************************
  // Absolute request pending; set at reset and by command, set wins
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      abs_pending <= 1'b1; // see RL7
    end else if (addr_ph && wr_ph && idx_ph == ABS_CMD_IDX && HWDATA_I[0]) begin
      abs_pending <= 1'b1;
    end else if (state == ST_IDLE && servo_d && !SERVO_CLK_I) begin
      abs_pending <= 1'b0;
    end
  end

  // Raw word trimmed to width above LSB position
  logic [7:0] width_f;
  logic [2:0] lsb_f;
  logic [3:0] lane_f;
  assign width_f = entry_width[WIDTH_LSB +: 8]; // see RL2
  assign lane_f  = entry_width[LANE_LSB +: 4];  // see RL4
  assign lsb_f   = entry_width[2:0];            // see RL5
  always_comb begin
    logic [23:0] mask;
    mask = 24'h0;
    next_raw = gathered >> lsb_f;   // see RL19
    for (int i = 0; i < 24; i++) begin
      mask[i] = (8'(i) < width_f);
    end
    next_raw = next_raw & mask;
  end

  // Shift and optional change limit
  always_comb begin
    logic [23:0] shifted;
    logic [23:0] delta;
    logic [3:0]  meth;
    meth = abs_cycle ? METHOD_PLAIN : entry_width[METHOD_LSB +: 4];
    shifted = (entry_addr[MODE_BIT] || abs_cycle) ? next_raw
                                                  : 24'(next_raw << FRACTION_BITS); // see RL17
    delta = shifted - last_pos;
    next_pos = shifted;
    if (first_done && (meth == METHOD_FILTER || meth == METHOD_FILTER_X)) begin // see RL1, RL6
      if (!delta[23] && delta > entry_limit) begin
        next_pos = last_pos + entry_limit;
      end else if (delta[23] && (24'h0 - delta) > entry_limit) begin
        next_pos = last_pos - entry_limit;
      end
    end
  end

  // Sequencer: wait after servo fall, fetch bytes, publish
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state     <= ST_IDLE;
      delay_cnt <= 16'h0;
      fetch_idx <= 2'd0;
      gathered  <= 24'h0;
      abs_cycle <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (servo_d && !SERVO_CLK_I) begin
            state     <= ST_WAIT;
            delay_cnt <= 16'(READ_DELAY_CYC - 1); // see RL9
            abs_cycle <= abs_pending;
          end
        end
        ST_WAIT: begin
          if (delay_cnt == 16'h0) begin
            state     <= ST_FETCH;
            fetch_idx <= 2'd0;
            gathered  <= 24'h0;
          end else begin
            delay_cnt <= delay_cnt - 16'h1;
          end
        end
        ST_FETCH: begin
          // Byte lane of each word, low address first
          gathered[fetch_idx*8 +: 8] <= abs_cycle
              ? board_byte(in_bytes, abs_src[19:0] + 20'(fetch_idx))        // see RL8
              : board_byte(in_bytes, entry_addr[18:0] + 20'(fetch_idx))     // see RL18
                & {8{lane_f == 4'h0}}; // Board data sits in lane 0, see RL4
          if (fetch_idx + 2'd1 >= (abs_cycle ? 2'd3 : byte_count(width_f))) begin
            state <= ST_DONE;
          end else begin
            fetch_idx <= fetch_idx + 2'd1;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Publish position
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      MOTOR_POSITION_O <= 24'h0;
      POSITION_VALID_O <= 1'b0;
      last_pos         <= 24'h0;
      first_done       <= 1'b0;
      abs_pos          <= 24'h0;
    end else begin
      POSITION_VALID_O <= 1'b0;
      if (state == ST_DONE) begin
        if (abs_cycle) begin
          // Low byte format only: bit 22 zero, last digit 4
          if (!abs_fmt[ABS_FMT_ZERO_BIT] && abs_fmt[3:0] == ABS_FMT_DIGIT) begin // see RL8
            abs_pos    <= next_raw;
            last_pos   <= entry_addr[MODE_BIT] ? next_raw : 24'(next_raw << FRACTION_BITS);
            first_done <= 1'b1;
          end
        end else begin
          MOTOR_POSITION_O <= next_pos;
          POSITION_VALID_O <= 1'b1;
          last_pos         <= next_pos;
          first_done       <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> verif/pfl_checker_props.sv
// Port checker for the parallel feedback reader
`timescale 1ns/10ps
module pfl_checker (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic        HREADY_I,
  input  wire logic [31:0] HRDATA_O,
  input  wire logic        HREADYOUT_O,
  input  wire logic        HRESP_O,
  input  wire logic        SERVO_CLK_I,
  input  wire logic [23:0] MOTOR_POSITION_O,
  input  wire logic        POSITION_VALID_O
);
  logic [9:0] since_fall;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  // Cycles since the last servo clock fall, saturating
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      since_fall <= 10'h3ff;
    end else if ($fell(SERVO_CLK_I)) begin
      since_fall <= 10'h000;
    end else if (since_fall != 10'h3ff) begin
      since_fall <= since_fall + 10'h001;
    end
  end

  // *****************************************
  // Bus and conversion timing
  // *****************************************
  sequence servo_fall;
    $fell(SERVO_CLK_I);
  endsequence
  sequence read_req;
    HSEL_I && HTRANS_I[1] && !HWRITE_I && HREADY_I;
  endsequence

  chk_ready_high: assert property (HREADYOUT_O)
    else $error("hreadyout went low");
  chk_resp_okay: assert property (!HRESP_O)
    else $error("error response seen");
  chk_reset_clear: assert property ($fell(SYS_RST_I) |->
    HRDATA_O == 32'h0 && MOTOR_POSITION_O == 24'h0 && !POSITION_VALID_O)
    else $error("outputs not clear after reset");
  chk_valid_single: assert property (POSITION_VALID_O |=> !POSITION_VALID_O)
    else $error("valid longer than one cycle");
  chk_valid_delay: assert property (POSITION_VALID_O |->
    since_fall >= 10'd199 && since_fall <= 10'd215)
    else $error("valid not about 2 us after servo fall");
  chk_no_early: assert property (servo_fall |-> !POSITION_VALID_O [*8])
    else $error("valid right after servo fall");
  chk_rdata_hold: assert property (!(HSEL_I && HTRANS_I[1] && !HWRITE_I && HREADY_I)
    |=> $stable(HRDATA_O))
    else $error("read data changed without read");
  chk_pos_holds: assert property (POSITION_VALID_O |=> $stable(MOTOR_POSITION_O) [*8])
    else $error("position moved after valid");
endmodule

bind parallel_feedback_latch_reader pfl_checker i_pfl_checker (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .SERVO_CLK_I(SERVO_CLK_I),
  .MOTOR_POSITION_O(MOTOR_POSITION_O), .POSITION_VALID_O(POSITION_VALID_O)
);

// >>> verif/pfl_encoder_model.sv
// Parallel absolute encoder model on the input pins
`timescale 1ns/10ps
module pfl_encoder_model (
  input  wire logic        CLK_I,
  input  wire logic [47:0] POS_I,
  input  wire logic        GRAY_I,
  input  wire logic        NOISE_I,
  input  wire logic [1:0]  FAULT_I,
  output logic      [47:0] PINS_O,
  output logic             FAULT_FIRST_N_O,
  output logic             FAULT_SECOND_N_O
);
  logic [47:0] noise = 48'h0;
  logic [23:0] a_gray;

  function automatic logic [7:0] g8(input logic [7:0] b);
    return b ^ (b >> 1);
  endfunction

  // Pattern that changes every cycle, mimics output transitions
  always @(posedge CLK_I) begin
    noise <= {noise[46:0], ~noise[47]};
  end

  // Port A optionally Gray coded byte by byte
  assign a_gray = {g8(POS_I[23:16]), g8(POS_I[15:8]), g8(POS_I[7:0])};
  assign PINS_O = {POS_I[47:24], GRAY_I ? a_gray : POS_I[23:0]} ^ (NOISE_I ? noise : 48'h0);
  // Active low error outputs
  assign FAULT_FIRST_N_O  = ~FAULT_I[0];
  assign FAULT_SECOND_N_O = ~FAULT_I[1];
endmodule

// >>> verif/parallel_feedback_latch_reader_test.sv
// Self-checking bench for the parallel feedback reader
`timescale 1ns/10ps
module parallel_feedback_latch_reader_test;
  import pfl_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic        servo = 1'b1, phase = 1'b0, station = 1'b0, jmp1 = 1'b1, jmp2 = 1'b1;
  logic        gray = 1'b0, noisy = 1'b0, fault_n1, fault_n2, mvalid;
  logic [1:0]  htrans = 2'b00, fault = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [47:0] pos = 48'hc3a5e7_2abcde, pins;
  logic [23:0] mpos, got_pos;
  logic [95:0] tbl[10] = '{
    {24'hff8c00, 24'h212000, 24'hc3a5e7, 24'h03579b}, {24'hf78c00, 24'h212000, 24'hc3a5e7, 24'h6af360},
    {24'hff8c03, 24'h205003, 24'hc3a5e7, 24'h00001c}, {24'hff8c04, 24'h210000, 24'hc3a5e7, 24'h00c3a5},
    {24'hff8c00, 24'h201007, 24'hc3a5e7, 24'h000001}, {24'hff8c03, 24'h218000, 24'hc3a5e7, 24'hc3a5e7},
    {24'hff8c03, 24'h318000, 24'hc3a6e7, 24'hc3a5f7}, {24'hff8c03, 24'h718000, 24'hc3a6e7, 24'hc3a607},
    {24'hff8c03, 24'h218000, 24'hc3a6e7, 24'hc3a6e7},
    {24'hff8c03, 24'h218100, 24'hc3a6e7, 24'h000000}};
  logic [31:0] bad[2] = '{32'h418004, 32'h018005};
  int          mismatches = 0, n_tests = 0, n_valid = 0;

  always #5 clk = ~clk;

  parallel_feedback_latch_reader i_parallel_feedback_latch_reader (
    .CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .FEEDBACK_PINS_I(pins),
    .SERVO_CLK_I(servo), .PHASE_CLK_I(phase), .STATION_MODE_I(station),
    .FEEDBACK_FAULT_IN_FIRST_N_I(fault_n1), .FEEDBACK_FAULT_IN_SECOND_N_I(fault_n2),
    .FAULT_POLARITY_JUMPER_FIRST_I(jmp1), .FAULT_POLARITY_JUMPER_SECOND_I(jmp2),
    .MOTOR_POSITION_O(mpos), .POSITION_VALID_O(mvalid));

  pfl_encoder_model i_pfl_encoder_model (
    .CLK_I(clk), .POS_I(pos), .GRAY_I(gray), .NOISE_I(noisy), .FAULT_I(fault),
    .PINS_O(pins), .FAULT_FIRST_N_O(fault_n1), .FAULT_SECOND_N_O(fault_n2));

  // Capture each converted position
  always @(posedge clk) begin
    if (mvalid === 1'b1) begin
      got_pos <= mpos;
      n_valid <= n_valid + 1;
    end
  end

  // *****************************************
  // Bus and sequencing tasks
  // *****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) mismatches++;
  endtask

  task automatic bus(input logic [19:0] idx, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {10'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [19:0] idx, input logic [31:0] v);
    logic [31:0] x;
    bus(idx, 1'b1, v, x);
  endtask

  task automatic rdc(input logic [19:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(idx, 1'b0, 32'h0, x);
    chk(x, exp);
  endtask

  task automatic servo_cycle();
    servo <= 1'b0;
    repeat (250) @(posedge clk);
    servo <= 1'b1;
    repeat (150) @(posedge clk);
  endtask

  task automatic conv(input logic [23:0] exp);
    int c;
    c = n_valid;
    servo_cycle();
    chk(32'(n_valid - c), 32'h1);
    chk({8'h0, got_pos}, {8'h0, exp});
  endtask

  task automatic phase_pulse();
    phase <= 1'b1;
    repeat (4) @(posedge clk);
    phase <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung bus or sequence
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  // *****************************************
  // Test sequence
  // *****************************************
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(CONTROL_IDX, {24'h0, CONTROL_RESET});
    rdc(ENTRY_WIDTH_IDX, 32'h218000);
    rdc(ABS_FMT_IDX, 32'h018004);
    rdc(20'h78cff, 32'h0);
    wr(ABS_SRC_IDX, 32'h78c00);
    servo_cycle();
    rdc(ABS_POS_IDX, 32'h2abcde);
    // Malformed format words leave the stored position alone
    pos[23:0] <= 24'h13579b;
    foreach (bad[i]) begin
      wr(ABS_FMT_IDX, bad[i]);
      wr(ABS_CMD_IDX, 32'h1);
      servo_cycle();
      rdc(ABS_POS_IDX, 32'h2abcde);
    end
    wr(ABS_FMT_IDX, 32'h018004);
    wr(ABS_CMD_IDX, 32'h1);
    servo_cycle();
    rdc(ABS_POS_IDX, 32'h13579b);
    // Gray bank for port A, then back to normal access
    wr(CONTROL_IDX, 32'h80);
    for (int i = 0; i < 3; i++)
      wr(PORT_A_LOW_IDX + 20'(i), 32'hff);
    wr(CONTROL_IDX, 32'h3f);
    wr(PORT_A_LOW_IDX, 32'h0);
    gray <= 1'b1;
    @(posedge clk);
    rdc(PORT_A_LOW_IDX, 32'h9b);
    rdc(PORT_B_LOW_IDX, 32'he7);
    // Entry layouts, widths, shifts and filtering
    wr(ENTRY_LIMIT_IDX, 32'h10);
    foreach (tbl[i]) begin
      pos[47:24] <= tbl[i][47:24];
      wr(ENTRY_ADDR_IDX, {8'h0, tbl[i][95:72]});
      wr(ENTRY_WIDTH_IDX, {8'h0, tbl[i][71:48]});
      conv(tbl[i][23:0]);
    end
    // Latch bank for port B
    wr(CONTROL_IDX, 32'hc0);
    for (int i = 0; i < 3; i++)
      wr(PORT_B_LOW_IDX + 20'(i), 32'hff);
    wr(CONTROL_IDX, 32'h3f);
    servo_cycle();
    pos[31:24] <= 8'h11;
    noisy <= 1'b1;
    rdc(PORT_B_LOW_IDX, 32'he7);
    rdc(PORT_B_LOW_IDX, 32'he7);
    noisy <= 1'b0;
    fault <= 2'b10;
    servo_cycle();
    rdc(PORT_B_LOW_IDX, 32'he7);
    fault <= 2'b00;
    jmp2 <= 1'b0;
    servo_cycle();
    rdc(PORT_B_LOW_IDX, 32'he7);
    jmp2 <= 1'b1;
    servo_cycle();
    rdc(PORT_B_LOW_IDX, 32'h11);
    // Station latching on the phase clock
    station <= 1'b1;
    wr(STATION_ONE_IDX, 32'hc0000000);
    wr(STATION_TWO_IDX, 32'hc0000000);
    pos[31:24] <= 8'h33;
    phase_pulse();
    pos[31:24] <= 8'h44;
    repeat (2) @(posedge clk);
    rdc(PORT_B_LOW_IDX, 32'h33);
    phase_pulse();
    rdc(PORT_B_LOW_IDX, 32'h44);
    report_and_stop();
  end
endmodule
